// ===== hdl/irq_bank.sv
`timescale 1ns/1ns
module irq_bank import sysctl_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [IRQ_W-1:0] evt_i,
  irq_bank_if.bank rb,
  output logic irq_o
);
  logic [IRQ_W-1:0] raw_ff;
  logic [IRQ_W-1:0] mask_ff;
  logic irq_ff;
  logic [IRQ_W-1:0] nxt_raw;
  logic [IRQ_W-1:0] clr_bits;
  logic [IRQ_W-1:0] nxt_mask;

  // write-one clears, but a same-cycle event wins so no edge is lost
  always_comb begin
    clr_bits = rb.clr_we ? (rb.wdata & IRQ_IMPL) : IRQ_RST;
    nxt_raw = ((raw_ff & ~clr_bits) | evt_i) & IRQ_IMPL;
    nxt_mask = rb.mask_we ? (rb.wdata & IRQ_IMPL) : mask_ff;
  end

  // raw sticky status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raw_ff <= IRQ_RST;
    end else begin
      raw_ff <= nxt_raw;
    end
  end

  // software mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_ff <= IRQ_RST;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  // level interrupt, registered from next raw and next mask so it never lags the
  // masked view, not even across a mask write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_raw & nxt_mask);
    end
  end

  assign rb.raw = raw_ff;
  assign rb.mask = mask_ff;
  assign rb.masked = raw_ff & mask_ff;
  assign irq_o = irq_ff;

  a_masked_and: assert property (@(posedge clk_i) disable iff (rst_i)
    rb.masked == (rb.raw & rb.mask))
    else $error("masked view differs from raw and mask");
  a_irq_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (irq_o == |($past(nxt_raw) & $past(nxt_mask))))
    else $error("interrupt does not track masked status");
  a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    (rb.clr_we && (evt_i & IRQ_IMPL) != IRQ_RST) |=> ((raw_ff & $past(evt_i) & IRQ_IMPL) ==
    ($past(evt_i) & IRQ_IMPL)))
    else $error("event lost against a clear");
  a_w1c_raw: assert property (@(posedge clk_i) disable iff (rst_i)
    (rb.clr_we && evt_i == IRQ_RST) |=> ((raw_ff & $past(rb.wdata) & IRQ_IMPL) == IRQ_RST))
    else $error("write one did not clear raw bit");
endmodule

// ===== hdl/irq_bank_if.sv
`timescale 1ns/1ns
interface irq_bank_if;
  import sysctl_pkg::*;
  logic mask_we;
  logic clr_we;
  logic [IRQ_W-1:0] wdata;
  logic [IRQ_W-1:0] raw;
  logic [IRQ_W-1:0] mask;
  logic [IRQ_W-1:0] masked;
  modport ctrl (output mask_we, output clr_we, output wdata,
                input raw, input mask, input masked);
  modport bank (input mask_we, input clr_we, input wdata,
                output raw, output mask, output masked);
endinterface

// ===== hdl/sysctl_irq_status_reset_cause.sv
`timescale 1ns/1ns
// Contract
// - pll lock flag bit 6 sets on ready timer expiry, write one clears
// - current limit flag bit 5 sets on regulator limit detect, write one clears
// - internal oscillator fault flag bit 4 sets on fault, write one clears
// - main oscillator fault flag bit 3 sets on fault, write one clears
// - regulator loss flag bit 2 sets on loss condition, write one clears
// - brownout flag bit 1 sets on brownout only if reset select clear
// - masked flag is raw and mask; any masked flag raises interrupt
// - writing one to masked flag also clears the raw bit same cycle
// - reset cause bits 31 to 6 read zero and ignore writes
// - reset cause takes its post-reset value from the reset cause
// - external reset sets bit 0 and clears all other cause bits
// - other reset causes except power-on set their bit and keep earlier bits
// - regulator reset sets cause bit 5
// - software reset sets cause bit 4
// - watchdog reset sets cause bit 3
// - brownout reset sets cause bit 2
// - power-on reset sets cause bit 1
module sysctl_irq_status_reset_cause import sysctl_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [SEL_W-1:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // detector status from the same clock domain
  input wire logic pll_ready_i,
  input wire logic cur_limit_i,
  input wire logic int_osc_fault_i,
  input wire logic main_osc_fault_i,
  input wire logic reg_loss_i,
  input wire logic brownout_i,
  // cause of the reset now being applied, valid while rst_i is high
  input wire logic cause_ext_i,
  input wire logic cause_por_i,
  input wire logic cause_bor_i,
  input wire logic cause_wdog_i,
  input wire logic cause_soft_i,
  input wire logic cause_reg_i,
  // to the reset generator and interrupt controller
  output logic brownout_reset_select_o,
  output logic irq_o
);
  logic ack_ff;
  logic [DAT_W-1:0] dat_ff;
  logic brsel_ff;
  logic [CAUSE_W-1:0] reset_cause_ff;
  logic req;
  logic wr_go;
  logic [DAT_W-1:0] nxt_dat;
  logic [IRQ_W-1:0] evt;
  logic [CAUSE_W-1:0] cause_vec;
  logic bank_irq;

  irq_bank_if rb ();

  // a request is any strobe inside a cycle
  assign req = wb_cyc_i && wb_stb_i;

  // writes land on the edge where the master sees ack, as classic
  // wishbone expects; only the low byte carries defined bits
  assign wr_go = req && wb_we_i && ack_ff && wb_sel_i[0];

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req && !ack_ff;
    end
  end

  // read mux; unmapped addresses answer with zero, never stall
  always_comb begin
    nxt_dat = '0;
    if (hit(wb_adr_i, RAW_OFS)) begin
      nxt_dat[IRQ_W-1:0] = rb.raw;
    end else if (hit(wb_adr_i, MASK_OFS)) begin
      nxt_dat[IRQ_W-1:0] = rb.mask;
    end else if (hit(wb_adr_i, MFLAG_OFS)) begin
      nxt_dat[IRQ_W-1:0] = rb.masked;
    end else if (hit(wb_adr_i, CAUSE_OFS)) begin
      nxt_dat[CAUSE_W-1:0] = reset_cause_ff;
    end else if (hit(wb_adr_i, PBC_OFS)) begin
      nxt_dat[BRSEL_BIT] = brsel_ff;
    end
  end

  // read data is captured with ack and held until the next request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= '0;
    end else if (req && !ack_ff) begin
      dat_ff <= nxt_dat;
    end
  end

  assign wb_dat_o = dat_ff;
  assign wb_ack_o = ack_ff;

  // brown-out action select: set means brown-out resets instead of interrupting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brsel_ff <= BRSEL_RST;
    end else if (wr_go && hit(wb_adr_i, PBC_OFS)) begin
      brsel_ff <= wb_dat_i[BRSEL_BIT];
    end
  end

  assign brownout_reset_select_o = brsel_ff;

  // detector events into the raw status positions
  always_comb begin
    evt = IRQ_RST;
    evt[PLL_LOCK_BIT] = pll_ready_i;
    evt[CUR_LIMIT_BIT] = cur_limit_i;
    evt[INT_OSC_BIT] = int_osc_fault_i;
    evt[MAIN_OSC_BIT] = main_osc_fault_i;
    evt[REG_LOSS_BIT] = reg_loss_i;
    // a brown-out that is to reset the part never reaches the flag
    evt[BROWNOUT_BIT] = brownout_i && !brsel_ff;
  end

  // register bank strobes; the clear write goes to the masked view
  assign rb.mask_we = wr_go && hit(wb_adr_i, MASK_OFS);
  assign rb.clr_we = wr_go && hit(wb_adr_i, MFLAG_OFS);
  assign rb.wdata = wb_dat_i[IRQ_W-1:0];

  irq_bank u_bank (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .evt_i(evt),
    .rb(rb.bank),
    .irq_o(bank_irq)
  );

  assign irq_o = bank_irq;

  // cause bits other than external, in their field positions
  always_comb begin
    cause_vec = '0;
    cause_vec[REG_BIT] = cause_reg_i;
    cause_vec[SWR_BIT] = cause_soft_i;
    cause_vec[WDOG_BIT] = cause_wdog_i;
    cause_vec[BOR_BIT] = cause_bor_i;
    cause_vec[POR_BIT] = cause_por_i;
  end

  // the cause register is loaded, not cleared, by reset; power-on has
  // no earlier history worth keeping, so it starts from this cause alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      if (cause_ext_i) begin
        reset_cause_ff <= CAUSE_EXT_ONLY;
      end else if (cause_por_i) begin
        reset_cause_ff <= cause_vec;
      end else begin
        reset_cause_ff <= reset_cause_ff | cause_vec;
      end
    end else if (wr_go && hit(wb_adr_i, CAUSE_OFS)) begin
      reset_cause_ff <= wb_dat_i[CAUSE_W-1:0];
    end
  end

  // bus handshake steps
  sequence s_req_start;
    req && !ack_ff;
  endsequence

  sequence s_ack_then_drop;
    ack_ff ##1 !ack_ff;
  endsequence

  a_ack_latency: assert property (@(posedge clk_i) disable iff (rst_i)
    s_req_start |=> s_ack_then_drop)
    else $error("ack not one cycle after request");

  a_ack_needs_req: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(ack_ff) |-> $past(req))
    else $error("ack without request");

  a_cause_hi_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_ff && !wb_we_i && hit(wb_adr_i, CAUSE_OFS)) |-> (wb_dat_o[DAT_W-1:CAUSE_W] == '0))
    else $error("reset cause upper bits not zero");

  a_mflag_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_req_start and (!wb_we_i && hit(wb_adr_i, MFLAG_OFS))) |=>
    (wb_dat_o[IRQ_W-1:0] == $past(rb.masked)) && (wb_dat_o[DAT_W-1:IRQ_W] == '0))
    else $error("masked status read wrong");

  a_cause_ext_only: assert property (@(posedge clk_i)
    (rst_i && cause_ext_i) |=> (reset_cause_ff == CAUSE_EXT_ONLY))
    else $error("external reset left other cause bits");

  a_cause_accum: assert property (@(posedge clk_i)
    (rst_i && !cause_ext_i && !cause_por_i) |=>
    (reset_cause_ff == ($past(reset_cause_ff) | $past(cause_vec))))
    else $error("reset causes not accumulated");

  a_cause_por: assert property (@(posedge clk_i)
    (rst_i && !cause_ext_i && cause_por_i) |=> reset_cause_ff[POR_BIT])
    else $error("power-on cause bit not set");

  a_cause_sources: assert property (@(posedge clk_i)
    (rst_i && !cause_ext_i) |=>
    ((reset_cause_ff & $past(cause_vec)) == $past(cause_vec)))
    else $error("reset source bit missing");

  a_cause_soft_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_go && hit(wb_adr_i, CAUSE_OFS)) |=> (reset_cause_ff == $past(wb_dat_i[CAUSE_W-1:0])))
    else $error("reset cause write not stored");

  a_cause_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr_go && hit(wb_adr_i, CAUSE_OFS)) |=> $stable(reset_cause_ff))
    else $error("reset cause changed outside reset or write");

  a_bor_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (brsel_ff && !rb.raw[BROWNOUT_BIT]) |=> !rb.raw[BROWNOUT_BIT])
    else $error("brownout flag set while reset selected");

  a_flag_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    pll_ready_i |=> rb.raw[PLL_LOCK_BIT])
    else $error("pll lock flag not set");

  a_limit_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    cur_limit_i |=> rb.raw[CUR_LIMIT_BIT])
    else $error("current limit flag not set");

  a_osc_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    (int_osc_fault_i && main_osc_fault_i) |=> (rb.raw[INT_OSC_BIT] && rb.raw[MAIN_OSC_BIT]))
    else $error("oscillator fault flags not set");

  a_loss_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (rb.clr_we && rb.wdata[REG_LOSS_BIT] && !reg_loss_i) |=> !rb.masked[REG_LOSS_BIT])
    else $error("regulator loss flag not cleared");

  a_irq_out: assert property (@(posedge clk_i) disable iff (rst_i)
    (rb.masked != IRQ_RST) |-> irq_o)
    else $error("masked flag set but no interrupt");
endmodule

// ===== hdl/sysctl_pkg.sv
package sysctl_pkg;
  // bus geometry
  localparam int ADR_W = 12;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;
  // register byte offsets
  localparam logic [11:0] PBC_OFS = 12'h030;
  localparam logic [11:0] RAW_OFS = 12'h050;
  localparam logic [11:0] MASK_OFS = 12'h054;
  localparam logic [11:0] MFLAG_OFS = 12'h058;
  localparam logic [11:0] CAUSE_OFS = 12'h05c;
  // interrupt field layout, shared by raw, mask and masked views
  localparam int IRQ_W = 7;
  localparam int PLL_LOCK_BIT = 6;
  localparam int CUR_LIMIT_BIT = 5;
  localparam int INT_OSC_BIT = 4;
  localparam int MAIN_OSC_BIT = 3;
  localparam int REG_LOSS_BIT = 2;
  localparam int BROWNOUT_BIT = 1;
  localparam logic [6:0] IRQ_IMPL = 7'h7e;
  localparam logic [6:0] IRQ_RST = 7'h00;
  // reset cause layout
  localparam int CAUSE_W = 6;
  localparam int EXT_BIT = 0;
  localparam int POR_BIT = 1;
  localparam int BOR_BIT = 2;
  localparam int WDOG_BIT = 3;
  localparam int SWR_BIT = 4;
  localparam int REG_BIT = 5;
  localparam logic [5:0] CAUSE_EXT_ONLY = 6'h01;
  // brown-out control layout
  localparam int BRSEL_BIT = 1;
  localparam logic BRSEL_RST = 1'b0;

  // address compare, used by every register select
  function automatic logic hit(input logic [11:0] adr, input logic [11:0] ofs);
    return adr == ofs;
  endfunction
endpackage

// ===== tb/test_sysctl_irq_status_reset_cause.sv
`timescale 1ns/1ns
module test_sysctl_irq_status_reset_cause;
  import sysctl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [ADR_W-1:0] wb_adr_i = 12'h000;
  logic [SEL_W-1:0] wb_sel_i = 4'hf;
  logic [DAT_W-1:0] wb_dat_i = 32'h0;
  logic [DAT_W-1:0] wb_dat_o;
  logic wb_ack_o, brownout_reset_select_o, irq_o;
  logic [6:1] evt = 6'h00;
  logic [5:0] cause = 6'h02;
  // reference model of the registers
  logic [31:0] m_raw, m_mask, m_cause, rd;
  logic m_bsel;
  logic [11:0] adrs [6] = '{12'h030, 12'h050, 12'h054, 12'h058, 12'h05c, 12'h0a0};
  logic [5:0] causes [4] = '{6'h08, 6'h10, 6'h04, 6'h20};
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 20675;
  int r;

  sysctl_irq_status_reset_cause dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pll_ready_i(evt[6]), .cur_limit_i(evt[5]), .int_osc_fault_i(evt[4]),
    .main_osc_fault_i(evt[3]), .reg_loss_i(evt[2]), .brownout_i(evt[1]),
    .cause_ext_i(cause[0]), .cause_por_i(cause[1]), .cause_bor_i(cause[2]),
    .cause_wdog_i(cause[3]), .cause_soft_i(cause[4]), .cause_reg_i(cause[5]),
    .brownout_reset_select_o(brownout_reset_select_o), .irq_o(irq_o));

  // 10 MHz system clock
  initial begin
    forever #50 clk_i = ~clk_i;
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // a hung handshake ends here rather than running forever
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // classic cycle; ack and data are taken at the rising edge that shows ack, then released
  task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] dat,
                    input logic [3:0] sel, output logic [31:0] rdat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // write plus model update; byte lane 0 holds every defined bit
  task automatic wr(input logic [11:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    wb(1'b1, adr, dat, sel, rd);
    if (sel[0]) begin
      case (adr)
        PBC_OFS: m_bsel = dat[1];
        MASK_OFS: m_mask = dat & 32'h7e;
        MFLAG_OFS: m_raw = m_raw & ~dat;
        CAUSE_OFS: m_cause = dat & 32'h3f;
        default: ;
      endcase
    end
  endtask

  function automatic logic [31:0] expect_rd(input logic [11:0] a);
    case (a)
      PBC_OFS: return {30'h0, m_bsel, 1'b0};
      RAW_OFS: return m_raw;
      MASK_OFS: return m_mask;
      MFLAG_OFS: return m_raw & m_mask;
      CAUSE_OFS: return m_cause;
      default: return 32'h0;
    endcase
  endfunction

  // one-cycle detector pulse; brown-out only lands while it is set to interrupt
  task automatic pulse(input logic [6:1] bits);
    @(posedge clk_i);
    evt <= bits;
    @(posedge clk_i);
    evt <= 6'h00;
    m_raw = m_raw | {25'h0, bits[6:2], bits[1] & ~m_bsel, 1'b0};
  endtask

  // reset carrying a cause; external wipes history, power-up has none to keep
  task automatic do_reset(input logic [5:0] c, input int n);
    @(posedge clk_i);
    rst_i <= 1'b1;
    cause <= c;
    repeat (n) @(posedge clk_i);
    rst_i <= 1'b0;
    cause <= 6'h00;
    if (c[0]) m_cause = 32'h01;
    else if (c[1]) m_cause = {26'h0, c};
    else m_cause = m_cause | {26'h0, c};
    m_raw = 32'h0;
    m_mask = 32'h0;
    m_bsel = 1'b0;
  endtask

  task automatic check_all();
    foreach (adrs[i]) begin
      wb(1'b0, adrs[i], 32'h0, 4'hf, rd);
      check_word(rd, expect_rd(adrs[i]));
    end
    @(negedge clk_i);
    check_flag(irq_o, |(m_raw & m_mask));
    check_flag(brownout_reset_select_o, m_bsel);
  endtask

  initial begin
    do_reset(6'h02, 8);
    check_all();
    // sticky causes pile up: watchdog, software, brown-out, regulator
    foreach (causes[i]) begin
      do_reset(causes[i], 2);
      check_all();
    end
    do_reset(6'h21, 2);
    check_all();
    wr(CAUSE_OFS, 32'hffffffff, 4'hf);
    check_all();
    wr(CAUSE_OFS, 32'h0, 4'hf);
    check_all();
    // each source alone, unmasked, then cleared by writing one
    wr(MASK_OFS, 32'hffffffff, 4'hf);
    for (int b = 1; b <= 6; b++) begin
      pulse(6'h01 << (b - 1));
      check_all();
      wr(MFLAG_OFS, 32'h1 << b, 4'hf);
      check_all();
    end
    // brown-out routed to reset must not flag; lane 0 off means no write
    wr(PBC_OFS, 32'h2, 4'hf);
    pulse(6'h01);
    check_all();
    wr(MASK_OFS, 32'h0, 4'he);
    check_all();
    // random mix of events, mask changes, clears and control writes
    repeat (30) begin
      r = $random(seed);
      case (r[1:0])
        2'd0: pulse(r[7:2]);
        2'd1: wr(MASK_OFS, r, 4'hf);
        2'd2: wr(MFLAG_OFS, r, 4'hf);
        default: wr(PBC_OFS, r, 4'hf);
      endcase
      check_all();
    end
    end_of_test();
  end
endmodule
